// [verilog/omc_clock_ctrl.sv]
// Behaviour
// - the three-bit select picks fast clock, fast clock over 2..64, or the slow sub clock at 111.
// - halt with both keep bits low enters sleep: cpu, system clock and sub clock off, slow osc on.
// - halt with fast-keep 0, slow-keep 1 enters standby_slow_only; system clock on only at 111.
// - halt with both keep bits high enters standby_both_osc with every clock but the cpu running.
// - halt with fast-keep 1, slow-keep 0 enters standby_fast_only; system clock off only at 111.
// - fast mode keeps the cpu and all clocks running.
// - in any halted mode state is held and execution waits at the halt.
// - a halt sets the power-down flag and clears the watchdog timeout flag.
// - entering a halted mode clears the watchdog counter, which then counts on.
// - the slow oscillator keeps running while the cpu is stopped, whatever slow-keep says.
// - enabling the fast oscillator first clears its stable flag, which sets once it is stable.
// - in slow mode the fast oscillator runs as the enable bit says while the select is 111, and always otherwise; the enable resets to 1.
// - fast/slow changes come only from select writes; a switch to slow waits for a stable slow osc.
// - unused bits of both control registers read as zero.
// - a halted mode is left on a wake-enabled pin falling edge, a system interrupt or watchdog overflow.
`timescale 1ns/10ps
`default_nettype none
module omc_clock_ctrl
  import omc_pkg::*;
#(
  parameter int PORT_W = 5,
  parameter int STAB_CYC = FAST_STAB_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu and watchdog events
  input wire omc_cpu_evt_t cpu_evt,
  // oscillator edges and status
  input wire logic fast_tick,
  input wire logic slow_tick,
  input wire logic slow_osc_ready,
  // wake-enabled port pins
  input wire logic [PORT_W-1:0] port_wake_n,
  // clock control outputs
  output omc_gate_t gate,
  output logic sys_tick,
  output omc_mode_t mode,
  output logic power_down_flag,
  output logic watchdog_timeout_flag,
  output logic wdt_clear,
  output logic irq
);

  if (PORT_W < 1 || STAB_CYC < 1 || STAB_CYC > 65535) begin : g_chk
    $error("omc_clock_ctrl: unsupported parameter values");
  end

  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = DIV_W'((7'h01 << sel) - 7'h01);
  endfunction : div_mask

  function automatic logic is_slow(input logic [2:0] sel);
    is_slow = (sel == SEL_SLOW);
  endfunction : is_slow

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] sel_reg;
  logic fkeep_reg;
  logic skeep_reg;
  logic fen_reg;
  logic fstab_reg;
  logic [15:0] stab_cnt_reg;
  logic [2:0] act_sel_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  omc_mode_t mode_reg;
  omc_mode_t mode_next;
  logic [IRQ_W-1:0] ist_reg;
  logic [IRQ_W-1:0] imk_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  logic [PORT_W-1:0] pin_s1_reg;
  logic [PORT_W-1:0] pin_s2_reg;
  logic [PORT_W-1:0] pin_d_reg;
  logic slow_s1_reg;
  logic slow_s2_reg;
  omc_gate_t gate_reg;
  omc_gate_t gate_next;
  logic tick_reg;
  logic pdf_reg;
  logic to_reg;
  logic wclr_reg;
  logic irq_reg;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = avs_read | avs_write;
  wire done = req & ~wait_reg;
  wire wr_lo = done & avs_write & avs_byteenable[0];
  wire wr_scc = wr_lo & (avs_address == OMC_OFS_SCC);
  wire wr_foc = wr_lo & (avs_address == OMC_OFS_FOC);
  wire wr_imk = wr_lo & (avs_address == OMC_OFS_IMK);
  wire rd_ist = done & avs_read & (avs_address == OMC_OFS_IST);
  wire [7:0] wd = avs_writedata[7:0];
  wire [7:0] scc_rd = {sel_reg, 3'h0, fkeep_reg, skeep_reg};
  wire [7:0] foc_rd = {6'h00, fstab_reg, fen_reg};
  wire [7:0] ist_rd = {{(8 - IRQ_W){1'b0}}, ist_reg};
  wire [7:0] imk_rd = {{(8 - IRQ_W){1'b0}}, imk_reg};
  wire [7:0] rd_mux = (avs_address == OMC_OFS_SCC) ? scc_rd :
                      (avs_address == OMC_OFS_FOC) ? foc_rd :
                      (avs_address == OMC_OFS_IST) ? ist_rd :
                      (avs_address == OMC_OFS_IMK) ? imk_rd : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // mode and wake
  wire run = (mode_reg == MD_FAST) | (mode_reg == MD_SLOW);
  wire [PORT_W-1:0] pin_fall = pin_d_reg & ~pin_s2_reg;
  wire wake = (|pin_fall) | cpu_evt.sys_irq | cpu_evt.wdt_overflow;
  wire halt_go = run & cpu_evt.halt;
  wire act_slow = is_slow(act_sel_reg);
  wire omc_mode_t run_mode = act_slow ? MD_SLOW : MD_FAST;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MD_FAST, MD_SLOW: begin
        if (cpu_evt.halt) begin
          case ({fkeep_reg, skeep_reg})
            2'b00: mode_next = MD_SLEEP;
            2'b01: mode_next = MD_STBY_SLOW;
            2'b11: mode_next = MD_STBY_BOTH;
            default: mode_next = MD_STBY_FAST;
          endcase
        end else begin
          mode_next = run_mode;
        end
      end
      MD_SLEEP, MD_STBY_SLOW, MD_STBY_BOTH, MD_STBY_FAST: begin
        if (wake) begin
          mode_next = run_mode;
        end
      end
      default: mode_next = run_mode;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // gate selection per mode
  always_comb begin
    gate_next = '0;
    gate_next.slow_osc = 1'b1;
    case (mode_next)
      MD_FAST: begin
        gate_next = '1;
      end
      MD_SLOW: begin
        gate_next.cpu = 1'b1;
        gate_next.sys = 1'b1;
        gate_next.sub = 1'b1;
        gate_next.fast_osc = fen_reg | ~is_slow(sel_reg);
      end
      MD_SLEEP: begin
        gate_next.cpu = 1'b0;
      end
      MD_STBY_SLOW: begin
        gate_next.sub = 1'b1;
        gate_next.sys = act_slow;
      end
      MD_STBY_BOTH: begin
        gate_next.sys = 1'b1;
        gate_next.fast_osc = 1'b1;
        gate_next.sub = 1'b1;
      end
      MD_STBY_FAST: begin
        gate_next.fast_osc = 1'b1;
        gate_next.sys = ~act_slow;
      end
      default: gate_next = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // clock source and divider
  // a switch happens only on an edge of the old clock and restarts the
  // divider, so the new divider counts a full period; after a switch to slow the first period can be short
  wire fast_src = fast_tick & fstab_reg;
  wire div_hit = (div_cnt_reg & div_mask(act_sel_reg)) == div_mask(act_sel_reg);
  wire src_tick = act_slow ? slow_tick : (fast_src & div_hit);
  wire tgt_ok = is_slow(sel_reg) ? slow_s2_reg : fstab_reg;
  wire do_switch = (sel_reg != act_sel_reg) & src_tick & tgt_ok;
  wire fen_rise = wr_foc & wd[FOC_EN] & ~fen_reg;
  wire fosc_on = gate_reg.fast_osc;
  wire stab_done = fosc_on & ~fstab_reg & (stab_cnt_reg >= 16'(STAB_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // interrupt events and status
  wire [IRQ_W-1:0] evt;
  assign evt[IRQ_HALT] = halt_go;
  assign evt[IRQ_WAKE] = ~run & wake;
  assign evt[IRQ_FSTAB] = stab_done;
  assign evt[IRQ_SWITCH] = do_switch;
  // a read clears only the bits it returned; a new event wins
  wire [IRQ_W-1:0] ist_clr = rd_ist ? rdata_reg[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] ist_next = (ist_reg & ~ist_clr) | evt;

  ////////////////////////////////////////////////////////////////////
  // synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      pin_d_reg <= '1;
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= port_wake_n;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      slow_s1_reg <= slow_osc_ready;
      slow_s2_reg <= slow_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) begin
        rdata_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_reg <= SEL_RST;
      fkeep_reg <= FKEEP_RST;
      skeep_reg <= SKEEP_RST;
      fen_reg <= FOC_EN_RST;
      imk_reg <= '0;
    end else begin
      if (wr_scc) begin
        sel_reg <= wd[SCC_SEL_MSB:SCC_SEL_LSB];
        fkeep_reg <= wd[SCC_FKEEP];
        skeep_reg <= wd[SCC_SKEEP];
      end
      if (wr_foc) begin
        fen_reg <= wd[FOC_EN];
      end
      if (wr_imk) begin
        imk_reg <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fast oscillator stable flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fstab_reg <= 1'b0;
      stab_cnt_reg <= 16'h0000;
    end else if (!fosc_on || fen_rise) begin
      fstab_reg <= 1'b0;
      stab_cnt_reg <= 16'h0000;
    end else if (stab_done) begin
      fstab_reg <= 1'b1;
    end else if (!fstab_reg) begin
      stab_cnt_reg <= stab_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // active source and divider
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      act_sel_reg <= SEL_RST;
      div_cnt_reg <= '0;
    end else if (do_switch) begin
      act_sel_reg <= sel_reg;
      div_cnt_reg <= '0;
    end else if (fast_src) begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode, gates and system tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_reg <= MD_FAST;
      gate_reg <= '1;
      tick_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      gate_reg <= gate_next;
      tick_reg <= src_tick & gate_next.sys;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power-down and watchdog flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pdf_reg <= 1'b0;
      to_reg <= 1'b0;
      wclr_reg <= 1'b0;
    end else begin
      wclr_reg <= halt_go | cpu_evt.wdt_clr_instr;
      if (halt_go) begin
        pdf_reg <= 1'b1;
      end else if (cpu_evt.wdt_clr_instr) begin
        pdf_reg <= 1'b0;
      end
      if (cpu_evt.wdt_overflow) begin
        to_reg <= 1'b1;
      end else if (halt_go | cpu_evt.wdt_clr_instr) begin
        to_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status and output
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ist_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      irq_reg <= |(ist_next & imk_reg);
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign gate = gate_reg;
  assign sys_tick = tick_reg;
  assign mode = mode_reg;
  assign power_down_flag = pdf_reg;
  assign watchdog_timeout_flag = to_reg;
  assign wdt_clear = wclr_reg;
  assign irq = irq_reg;

endmodule : omc_clock_ctrl
`default_nettype wire

// [verilog/omc_pkg.sv]
`default_nettype none
package omc_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] OMC_OFS_SCC = 4'h0;
  localparam logic [3:0] OMC_OFS_FOC = 4'h4;
  localparam logic [3:0] OMC_OFS_IST = 4'h8;
  localparam logic [3:0] OMC_OFS_IMK = 4'hC;
  // system_clock_control fields
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_SEL_MSB = 7;
  localparam int SCC_FKEEP = 1;
  localparam int SCC_SKEEP = 0;
  // fast_oscillator_control fields
  localparam int FOC_FLAG = 1;
  localparam int FOC_EN = 0;
  // reset values
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic FKEEP_RST = 1'b0;
  localparam logic SKEEP_RST = 1'b0;
  localparam logic FOC_EN_RST = 1'b1;
  // select codes
  localparam logic [2:0] SEL_FAST_MAX = 3'h6;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_HALT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_FSTAB = 2;
  localparam int IRQ_SWITCH = 3;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int FAST_STAB_NS = 16000;
  localparam int FAST_STAB_CYC = (FAST_STAB_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_W = 6;

  typedef enum logic [2:0] {
    MD_FAST, MD_SLOW, MD_SLEEP, MD_STBY_SLOW, MD_STBY_BOTH, MD_STBY_FAST
  } omc_mode_t;

  // clock gates handed to the core and peripherals
  typedef struct packed {
    logic cpu;
    logic sys;
    logic fast_osc;
    logic sub;
    logic slow_osc;
  } omc_gate_t;

  // same-domain events from the cpu and watchdog
  typedef struct packed {
    logic halt;
    logic wdt_clr_instr;
    logic wdt_overflow;
    logic sys_irq;
  } omc_cpu_evt_t;
endpackage : omc_pkg
`default_nettype wire

// [testbench/omc_clock_ctrl_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module omc_clock_ctrl_chk
  import omc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // events and mode outputs
  input wire omc_cpu_evt_t cpu_evt,
  input wire omc_gate_t gate,
  input wire omc_mode_t mode,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic wdt_clear,
  input wire logic sys_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire run = (mode == MD_FAST) || (mode == MD_SLOW);
  sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_done; !avs_waitrequest ##1 avs_waitrequest; endsequence
  // overflow wins the timeout flag, so it is kept out of the plain halt case
  sequence s_halt; cpu_evt.halt && run && !cpu_evt.wdt_overflow; endsequence
  sequence s_halted; !run && !gate.cpu && gate.slow_osc && power_down_flag; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_bus_answer: assert property (s_taken |=> s_done)
    else $error("bus answer not one cycle");
  chk_halt_entry: assert property (s_halt |=> s_halted ##0 (!watchdog_timeout_flag && wdt_clear))
    else $error("halt entry wrong");
  chk_clear_pulse: assert property ($rose(wdt_clear) |=> !wdt_clear)
    else $error("watchdog clear not one cycle");
  chk_sleep_gates: assert property (mode == MD_SLEEP |-> gate == 5'h01)
    else $error("sleep gates wrong");
  chk_both_gates: assert property (mode == MD_STBY_BOTH |-> gate == 5'h0F)
    else $error("both-osc standby gates wrong");
  chk_slowonly_gates: assert property (mode == MD_STBY_SLOW |-> !gate.cpu && !gate.fast_osc && gate.sub && gate.slow_osc)
    else $error("slow-only standby gates wrong");
  chk_fastonly_gates: assert property (mode == MD_STBY_FAST |-> !gate.cpu && gate.fast_osc && !gate.sub && gate.slow_osc)
    else $error("fast-only standby gates wrong");
  chk_fast_gates: assert property (mode == MD_FAST |-> gate == 5'h1F)
    else $error("fast mode gates wrong");
  chk_pdf_cause: assert property ($rose(power_down_flag) |-> $past(cpu_evt.halt))
    else $error("power-down flag set without halt");
  chk_clr_pdf: assert property (cpu_evt.wdt_clr_instr && !cpu_evt.halt |=> !power_down_flag)
    else $error("clear instruction left power-down flag");
  chk_to_set: assert property (cpu_evt.wdt_overflow |=> watchdog_timeout_flag)
    else $error("overflow did not set timeout flag");
  chk_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_tick_gated: assert property (!gate.sys |-> !sys_tick)
    else $error("system tick while system clock gated");
endmodule : omc_clock_ctrl_chk

bind omc_clock_ctrl omc_clock_ctrl_chk u_chk (.ref_clk, .rst_n, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .cpu_evt, .gate, .mode, .power_down_flag,
  .watchdog_timeout_flag, .wdt_clear, .sys_tick);
`default_nettype wire

// [testbench/omc_clock_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module omc_clock_ctrl_tb_top
  import omc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  omc_cpu_evt_t cpu_evt = '0;
  logic fast_tick = 1'b0;
  logic slow_tick = 1'b0;
  logic [4:0] port_wake_n = 5'h1F;
  // slow oscillator starts unready so the switch to slow has to wait for it
  logic slow_osc_ready = 1'b0;
  int polls;
  logic [7:0] cyc = 8'h0;
  omc_gate_t gate;
  omc_mode_t mode;
  logic sys_tick, power_down_flag, watchdog_timeout_flag, wdt_clear, irq;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] q;
  logic [1:0] k;
  logic slw;
  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 ref_clk = ~ref_clk;
  // oscillator strobes at fixed rates; the slow one is sparse to stretch switches
  always @(posedge ref_clk) begin
    fast_tick <= ~fast_tick;
    cyc <= cyc + 8'h1;
    slow_tick <= (cyc[1:0] == 2'h0);
  end
  // short stabilise count keeps the run brief
  omc_clock_ctrl #(.PORT_W(5), .STAB_CYC(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_evt(cpu_evt),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .slow_osc_ready(slow_osc_ready),
    .port_wake_n(port_wake_n), .gate(gate), .sys_tick(sys_tick), .mode(mode),
    .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag),
    .wdt_clear(wdt_clear), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64) begin
      mismatches++;
      results();
    end
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, q)
  endtask : rd
  task automatic evt(input int b);
    @(posedge ref_clk);
    cpu_evt[b] <= 1'b1;
    @(posedge ref_clk);
    cpu_evt[b] <= 1'b0;
    #1;
  endtask : evt
  task automatic wait_mode(input omc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      results();
    end
    #1;
  endtask : wait_mode
  // cycles between two system ticks, read settled after each edge
  task automatic period(input int e, input string nm);
    int n;
    int p;
    n = 0;
    p = 0;
    while (sys_tick !== 1'b1 && n < 600) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    do begin
      @(posedge ref_clk);
      #1;
      p++;
    end while (sys_tick !== 1'b1 && p < 300);
    `CHK(nm, e, p)
  endtask : period
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00, "ctl_rst");
    rd(4'h4, 8'h01, "osc_rst");
    `CHK("gate_fast", 5'h1F, gate)
    tick(20);
    rd(4'h4, 8'h03, "osc_stab");
    // fast strobe comes every other cycle, so the tick period is 2 times the divisor
    for (int s = 0; s < 7; s += 3) begin
      bus(1'b1, 4'h0, {s[2:0], 5'h00});
      tick(20);
      period(2 << s, "div");
    end
    bus(1'b1, 4'hC, 8'h00);
    tick(3);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, 4'hC, 8'h0F);
    tick(3);
    `CHK("irq_on", 1'b1, irq)
    bus(1'b1, 4'h0, 8'hFF);
    tick(20);
    `CHK("slow_wait", MD_FAST, mode)
    @(posedge ref_clk);
    slow_osc_ready <= 1'b1;
    wait_mode(MD_SLOW);
    period(4, "div_slow");
    rd(4'h0, 8'hE3, "ctl_unused");
    bus(1'b1, 4'h4, 8'hFF);
    rd(4'h4, 8'h03, "osc_unused");
    rd(4'h2, 8'h00, "unmapped");
    $display("test registers done");
    // every keep-bit pair from both run modes, waking by each source in turn
    for (int i = 0; i < 8; i++) begin
      k = i[1:0];
      slw = i[2];
      bus(1'b1, 4'h0, {slw ? 3'h7 : 3'h0, 3'h0, k});
      wait_mode(slw ? MD_SLOW : MD_FAST);
      evt(3);
      `CHK("mode", k == 2'h0 ? MD_SLEEP : k == 2'h1 ? MD_STBY_SLOW : k == 2'h3 ? MD_STBY_BOTH : MD_STBY_FAST, mode)
      `CHK("sys_gate", k == 2'h3 || (k == 2'h1 && slw) || (k == 2'h2 && !slw), gate.sys)
      `CHK("flags", 3'h5, {power_down_flag, watchdog_timeout_flag, wdt_clear})
      `CHK("gates", {1'b0, k[1], k[0], 1'b1}, {gate.cpu, gate.fast_osc, gate.sub, gate.slow_osc})
      if (i % 3 == 1) begin
        @(posedge ref_clk);
        port_wake_n <= 5'h1E;
      end else begin
        evt(i % 3 == 0 ? 0 : 1);
      end
      wait_mode(slw ? MD_SLOW : MD_FAST);
      @(posedge ref_clk);
      port_wake_n <= 5'h1F;
      if (i % 3 == 2) `CHK("to_wake", 1'b1, watchdog_timeout_flag)
    end
    $display("test halt modes done");
    evt(2);
    `CHK("pdf_clr", 1'b0, power_down_flag)
    bus(1'b1, 4'h4, 8'h00);
    tick(2);
    `CHK("fast_off", 1'b0, gate.fast_osc)
    bus(1'b1, 4'h4, 8'h01);
    rd(4'h4, 8'h01, "stab_clr");
    polls = 0;
    do begin
      bus(1'b0, 4'h4, 8'h00);
      polls++;
    end while (q[1] !== 1'b1 && polls < 40);
    rd(4'h4, 8'h03, "stab_set");
    bus(1'b1, 4'h0, 8'h00);
    wait_mode(MD_FAST);
    period(2, "div_back");
    rd(4'h8, 8'h0F, "status");
    rd(4'h8, 8'h00, "status_clr");
    tick(3);
    `CHK("irq_off", 1'b0, irq)
    $display("test oscillator and irq done");
    results();
  end
endmodule : omc_clock_ctrl_tb_top
`default_nettype wire
